// ### rtl/anc_pkg.sv
// Constants and types shared by the ancillary extraction buffer block.
package anc_pkg;

  // Buffer mode field encodings.
  localparam logic [1:0] MODE_VIDEO   = 2'h0;
  localparam logic [1:0] MODE_STREAM  = 2'h1;
  localparam logic [1:0] MODE_EXTRACT = 2'h2;
  localparam logic [1:0] MODE_BYPASS  = 2'h3;
  localparam logic [1:0] MODE_RESET   = 2'h0;

  // Timing figures in pixel-clock cycles.
  localparam int INIT_CYCLES     = 2200;
  localparam int SWAP_GAP_CYCLES = 1100;

  // Documented half size in words.
  localparam int HALF_WORDS = 1024;

  // Host read window for captured words.
  localparam int         RD_ADDR_W = 11;
  localparam logic [10:0] RD_BASE  = 11'h02C;
  localparam logic [10:0] RD_LAST  = 11'h42B;

  // Parallel output bit positions in stream mode.
  localparam int DOUT_ERR_BIT   = 9;
  localparam int DOUT_STUFF_BIT = 8;

  // Synchronised pin vector positions.
  localparam int PIN_RESET_N = 0;
  localparam int PIN_BUF_EN  = 1;
  localparam int PIN_PROC_EN = 2;
  localparam int PIN_VIDEO   = 3;
  localparam int PIN_STREAM  = 4;
  localparam int PIN_LINK    = 5;
  localparam int PIN_COUNT   = 6;

  // Bank-swap phases, Gray coded along the cycle A-B-C-D.
  typedef enum logic [1:0] {
    PH_A = 2'b00,
    PH_B = 2'b01,
    PH_C = 2'b11,
    PH_D = 2'b10
  } phase_t;

endpackage

// ### rtl/pin_sync.sv
// Two-flop synchroniser for a vector of independent pin levels.
`timescale 1ns/1ps
module pin_sync
  import anc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
    end
  end

  assign o_sync = stage2_reg;

endmodule

// ### rtl/anc_extract_fifo_and_parallel_out.sv
// Ancillary extraction ping-pong buffer, bypass control and parallel output.
`timescale 1ns/1ps
//
// Functional notes
// R01: Capture starts from next frame after enable.
// R02: No capture for 2200 cycles after entry.
// R03: Processing pin low blocks capture, ignores enable.
// R04: Only bypass stops capture; re-entry resumes. Code also stops capture on a host write of mode 00b or 01b, with bypass low.
// R05: Present flag high while ancillary data detected.
// R06: Packets stored sequentially; count word at plus three.
// R07: Fill first half; drop data when full.
// R08: First swap: write second half from zero.
// R09: Second swap: clear first half, read second.
// R10: Third swap: write first half from zero.
// R11: Fourth swap: clear second half, restart cycle.
// R12: Host spaces swaps at least 1100 cycles.
// R13: Host swaps only while present flag low.
// R14: Host clears via extract mode, two pulses.
// R15: Host clears via buffer-enable pin low-high.
// R16: Bypass on pin low or mode 11b.
// R17: Bypass routes around buffer, buffer static.
// R18: Format pins select raw, video or stream.
// R19: Reset pin tri-states outputs, status holds.
// R20: Video mode outputs aligned ten-bit words.
// R21: Stream mode: byte low, error, stuffing bits.
// R22: Raw data through; auto forces low unsynced.
// R23: Extraction splits buffer into two 1024 halves.
// R24: Host reads words over 02Ch to 42Bh.
// R25: Swap detected against previous registered value.
module anc_extract_fifo_and_parallel_out
  import anc_pkg::*;
#(
  parameter int HALF_DEPTH = HALF_WORDS
)
(
  input  wire logic                 i_clock,
  input  wire logic                 i_sys_rst,
  input  wire logic                 i_link_clock,
  input  wire logic                 i_reset_n_pin,
  input  wire logic                 i_buffer_enable_pin,
  input  wire logic                 i_processing_enable_pin,
  input  wire logic                 i_video_format_pin,
  input  wire logic                 i_stream_format_pin,
  input  wire logic                 i_mode_write,
  input  wire logic [1:0]           i_mode_wdata,
  input  wire logic                 i_anc_capture_enable,
  input  wire logic                 i_anc_bank_swap,
  input  wire logic                 i_frame_start,
  input  wire logic                 i_anc_valid,
  input  wire logic [7:0]           i_anc_word,
  input  wire logic [9:0]           i_video_word,
  input  wire logic [7:0]           i_stream_byte,
  input  wire logic                 i_code_error_flag,
  input  wire logic                 i_stuffing_flag,
  input  wire logic                 i_auto_mode,
  input  wire logic                 i_trs_found,
  input  wire logic                 i_sync_found,
  input  wire logic                 i_rd_en,
  input  wire logic [RD_ADDR_W-1:0] i_rd_addr,
  output logic      [1:0]           o_mode,
  output logic                      o_bypass,
  output logic                      o_anc_buffer_ready,
  output logic                      o_anc_present_flag,
  output logic      [7:0]           o_rd_data,
  output logic                      o_rd_valid,
  output logic      [9:0]           o_dout,
  output logic                      o_dout_oe_n,
  output logic                      o_pclk,
  output logic                      o_pclk_oe_n
);

  localparam int IDX_W = $clog2(HALF_DEPTH);
  localparam int PTR_W = IDX_W + 1;
  localparam logic [PTR_W-1:0] HALF_FULL = PTR_W'(HALF_DEPTH);
  localparam logic [11:0] INIT_LOAD = 12'(INIT_CYCLES);
  localparam int INIT_M1 = INIT_CYCLES - 1;

  generate
    if (HALF_DEPTH < 2 || HALF_DEPTH != (1 << IDX_W)
        || HALF_DEPTH > HALF_WORDS)
    begin : g_bad_depth
      $error("HALF_DEPTH must be a power of two up to the window size");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and derived mode state.

  logic [PIN_COUNT-1:0] pins_s;

  pin_sync #(
    .WIDTH (PIN_COUNT)
  ) u_pin_sync (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_link_clock, i_stream_format_pin, i_video_format_pin,
                 i_processing_enable_pin, i_buffer_enable_pin,
                 i_reset_n_pin}),
    .o_sync    (pins_s)
  );

  logic rst_pin_n_s;
  logic buf_en_s;
  logic proc_en_s;
  logic video_s;
  logic stream_s;
  logic link_s;
  logic raw_fmt;
  logic ext_mode;

  assign rst_pin_n_s = pins_s[PIN_RESET_N];
  assign buf_en_s    = pins_s[PIN_BUF_EN];
  assign proc_en_s   = pins_s[PIN_PROC_EN];
  assign video_s     = pins_s[PIN_VIDEO];
  assign stream_s    = pins_s[PIN_STREAM];
  assign link_s      = pins_s[PIN_LINK];
  assign raw_fmt     = !video_s && !stream_s;

  logic [1:0] mode_reg;
  logic       raw_prev_reg;

  // Host writes win; a fresh move to raw format loads bypass.
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      mode_reg     <= MODE_RESET;
      raw_prev_reg <= 1'b0;
    end
    else
    begin
      raw_prev_reg <= raw_fmt;
      if (i_mode_write)
        mode_reg <= i_mode_wdata;
      else if (raw_fmt && !raw_prev_reg)
        mode_reg <= MODE_BYPASS;  // [R16]
    end
  end

  assign ext_mode = buf_en_s && proc_en_s && (mode_reg == MODE_EXTRACT);

  logic bypass_next;
  logic bypass_reg;
  assign bypass_next = !buf_en_s || !proc_en_s
                       || (mode_reg == MODE_BYPASS);  // [R16]

  ////////////////////////////////////////////////////////////////////////
  // Initialisation hold-off and capture arming.

  logic        ext_prev_reg;
  logic [11:0] init_cnt_reg;
  logic        ready_reg;
  logic        armed_reg;
  logic        ever_armed_reg;
  logic        wr_en;

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      ext_prev_reg <= 1'b0;
      init_cnt_reg <= '0;
      ready_reg    <= 1'b0;
    end
    else
    begin
      ext_prev_reg <= ext_mode;
      if (!ext_mode)
      begin
        init_cnt_reg <= '0;
        ready_reg    <= 1'b0;
      end
      else if (!ext_prev_reg)
        init_cnt_reg <= INIT_LOAD - 12'h001;  // [R02]
      else if (init_cnt_reg != '0)
        init_cnt_reg <= init_cnt_reg - 12'h001;
      else
        ready_reg <= 1'b1;
    end
  end

  // Clearing the enable does not disarm; only leaving the mode does.
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      armed_reg      <= 1'b0;
      ever_armed_reg <= 1'b0;
    end
    else if (!ext_mode)
      armed_reg <= 1'b0;  // [R04] [R03]
    else if (ready_reg && i_anc_capture_enable
             && (i_frame_start || ever_armed_reg))
    begin
      armed_reg      <= 1'b1;  // [R01] [R04]
      ever_armed_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bank swap sequencing and the two buffer halves.

  phase_t           phase_reg;
  logic             swap_prev_reg;
  logic             swap_evt;
  logic             wr_bank_reg;
  logic             rd_bank_reg;
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] fill_reg [2];
  logic [7:0]       mem [2*HALF_DEPTH];

  // The host keeps swaps spaced and away from live packets. [R12] [R13]
  assign swap_evt = ext_mode && (i_anc_bank_swap != swap_prev_reg);  // [R25]
  assign wr_en = ext_mode && armed_reg && ready_reg && proc_en_s
                 && i_anc_valid && (wr_ptr_reg != HALF_FULL);  // [R07]

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      swap_prev_reg <= 1'b0;
    else
      swap_prev_reg <= i_anc_bank_swap;  // [R25]
  end

  // Leaving the mode empties both halves, which gives the pin clear.
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst || !ext_mode)
    begin
      phase_reg   <= PH_A;  // [R15] [R17]
      wr_bank_reg <= 1'b0;
      rd_bank_reg <= 1'b0;
      wr_ptr_reg  <= '0;
      fill_reg[0] <= '0;
      fill_reg[1] <= '0;
    end
    else if (swap_evt)
    begin
      case (phase_reg)
        PH_A:
        begin
          phase_reg   <= PH_B;
          wr_bank_reg <= 1'b1;  // [R08]
          wr_ptr_reg  <= '0;
          rd_bank_reg <= 1'b0;
        end
        PH_B:
        begin
          phase_reg   <= PH_C;
          fill_reg[0] <= '0;  // [R09]
          rd_bank_reg <= 1'b1;
        end
        PH_C:
        begin
          phase_reg   <= PH_D;
          wr_bank_reg <= 1'b0;  // [R10]
          wr_ptr_reg  <= '0;
          rd_bank_reg <= 1'b1;
        end
        default:
        begin
          phase_reg   <= PH_A;
          fill_reg[1] <= '0;  // [R11]
          rd_bank_reg <= 1'b0;
        end
      endcase
    end
    else if (wr_en)
    begin
      wr_ptr_reg            <= wr_ptr_reg + PTR_W'(1);  // [R06]
      fill_reg[wr_bank_reg] <= wr_ptr_reg + PTR_W'(1);
    end
  end

  // Words land in arrival order, so the count word sits three after the flag.
  always_ff @(posedge i_clock)
  begin
    if (wr_en && !swap_evt)
      mem[{wr_bank_reg, wr_ptr_reg[IDX_W-1:0]}] <= i_anc_word;  // [R06] [R23]
  end

  ////////////////////////////////////////////////////////////////////////
  // Host read window.

  logic [RD_ADDR_W-1:0] rd_off;
  logic                 rd_hit;
  assign rd_off = i_rd_addr - RD_BASE;
  assign rd_hit = (i_rd_addr >= RD_BASE) && (i_rd_addr <= RD_LAST)
                  && (rd_off < RD_ADDR_W'(HALF_DEPTH));

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_rd_data  <= 8'h00;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en && rd_hit && ready_reg
          && (PTR_W'(rd_off) < fill_reg[rd_bank_reg]))
        o_rd_data <= mem[{rd_bank_reg, rd_off[IDX_W-1:0]}];  // [R24]
      else
        o_rd_data <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status outputs; the present flag holds while the reset pin is low.

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_anc_present_flag <= 1'b0;
      o_anc_buffer_ready <= 1'b0;
      bypass_reg         <= 1'b1;
    end
    else
    begin
      if (rst_pin_n_s)
        o_anc_present_flag <= i_anc_valid;  // [R05] [R19]
      o_anc_buffer_ready <= ready_reg;
      bypass_reg         <= bypass_next;  // [R16]
    end
  end

  assign o_mode   = mode_reg;
  assign o_bypass = bypass_reg;

  ////////////////////////////////////////////////////////////////////////
  // Parallel output, launched on each sampled link clock rising edge.

  logic       link_prev_reg;
  logic [9:0] dout_next;

  always_comb
  begin
    if (stream_s)
      dout_next = {i_code_error_flag, i_stuffing_flag, i_stream_byte};  // [R21]
    else if (video_s)
      dout_next = i_video_word;  // [R20] [R18]
    else if (i_auto_mode && !i_trs_found && !i_sync_found)
      dout_next = 10'h000;  // [R22]
    else
      dout_next = i_video_word;  // [R22] [R18]
  end

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      link_prev_reg <= 1'b0;
      o_dout        <= 10'h000;
      o_pclk        <= 1'b0;
      o_dout_oe_n   <= 1'b1;
      o_pclk_oe_n   <= 1'b1;
    end
    else
    begin
      link_prev_reg <= link_s;
      o_pclk        <= link_s;  // [R17]
      o_dout_oe_n   <= !rst_pin_n_s;  // [R19]
      o_pclk_oe_n   <= !rst_pin_n_s;  // [R19]
      if (link_s && !link_prev_reg)
        o_dout <= dout_next;  // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence ext_entry_s;
    ext_mode && !ext_prev_reg;
  endsequence

  sequence swap_in_s(phase_t ph);
    swap_evt && (phase_reg == ph);
  endsequence

  init_load_a: assert property (ext_entry_s
                                |=> init_cnt_reg == INIT_M1)  // [R02]
    else $error("hold-off counter not loaded on entry");
  init_hold_a: assert property (wr_en |-> ready_reg && init_cnt_reg == '0)  // [R02]
    else $error("capture during hold-off");
  proc_block_a: assert property (!proc_en_s |-> !wr_en
                                 ##1 !armed_reg && !ready_reg)  // [R03]
    else $error("capture with processing pin low");
  keep_armed_a: assert property (armed_reg && ext_mode
                                 ##1 ext_mode |-> armed_reg)  // [R04]
    else $error("capture stopped without bypass");
  arm_frame_a: assert property ($rose(armed_reg) && !$past(ever_armed_reg)
                                |-> $past(i_frame_start))  // [R01]
    else $error("capture armed mid frame");
  present_flag_a: assert property (i_anc_valid && rst_pin_n_s
                                   |=> o_anc_present_flag)  // [R05]
    else $error("present flag missed");
  full_drop_a: assert property (wr_ptr_reg == HALF_FULL && ext_mode
                                && !swap_evt |-> !wr_en
                                ##1 wr_ptr_reg == HALF_FULL)  // [R07]
    else $error("write past full half");
  swap_first_a: assert property (swap_in_s(PH_A) |=>
                                 wr_bank_reg && wr_ptr_reg == '0
                                 && !rd_bank_reg)  // [R08]
    else $error("first swap wrong");
  swap_second_a: assert property (swap_in_s(PH_B) |=>
                                  fill_reg[0] == '0 && rd_bank_reg
                                  && wr_bank_reg)  // [R09]
    else $error("second swap wrong");
  swap_third_a: assert property (swap_in_s(PH_C) |=>
                                 !wr_bank_reg && wr_ptr_reg == '0
                                 && rd_bank_reg)  // [R10]
    else $error("third swap wrong");
  swap_fourth_a: assert property (swap_in_s(PH_D) |=>
                                  phase_reg == PH_A && fill_reg[1] == '0
                                  && !rd_bank_reg)  // [R11]
    else $error("fourth swap wrong");
  bypass_pin_a: assert property (!buf_en_s
                                 |=> o_bypass && !armed_reg)  // [R16]
    else $error("bypass not taken");
  reset_tri_a: assert property (!rst_pin_n_s |=> o_dout_oe_n && o_pclk_oe_n
                                && $stable(o_anc_present_flag))  // [R19]
    else $error("outputs driven during reset pin");

endmodule

// ### tb/anc_source.sv
// Application-side ancillary packet source and link clock for the bench.
`timescale 1ns/1ps
module anc_source
(
  input  wire logic i_clock,
  output logic      o_link_clock,
  output logic      o_anc_valid,
  output logic [7:0] o_anc_word
);
  initial
  begin
    o_link_clock = 1'b0;
    o_anc_valid  = 1'b0;
    o_anc_word   = 8'h5A;
  end

  // The parallel clock runs free, so the link clock never stops.
  always #80 o_link_clock = ~o_link_clock;

  // Sends n words; word three carries the user word count.
  task automatic send(input logic [7:0] base, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_clock);
      #1;
      o_anc_valid = 1'b1;
      o_anc_word  = (i == 3) ? 8'(n - 5) : base + 8'(i);
    end
    @(posedge i_clock);
    #1;
    o_anc_valid = 1'b0;
    // A released word line must not keep showing the last value.
    o_anc_word  = ~o_anc_word;
  endtask
endmodule

// ### tb/anc_extract_fifo_and_parallel_out_tb.sv
// Self-checking bench for the ancillary extraction buffer block.
`timescale 1ns/1ps
module anc_extract_fifo_and_parallel_out_tb;
  import anc_pkg::*;
  localparam int DEPTH = 16;
  logic i_clock, i_sys_rst, i_link_clock, i_reset_n_pin;
  logic i_buffer_enable_pin, i_processing_enable_pin;
  logic i_video_format_pin, i_stream_format_pin, i_mode_write;
  logic [1:0] i_mode_wdata, o_mode;
  logic i_anc_capture_enable, i_anc_bank_swap, i_frame_start;
  logic i_anc_valid, i_code_error_flag, i_stuffing_flag;
  logic [7:0] i_anc_word, i_stream_byte, o_rd_data;
  logic [9:0] i_video_word, o_dout;
  logic i_auto_mode, i_trs_found, i_sync_found, i_rd_en;
  logic [RD_ADDR_W-1:0] i_rd_addr;
  logic o_bypass, o_anc_buffer_ready, o_anc_present_flag, o_rd_valid;
  logic o_dout_oe_n, o_pclk, o_pclk_oe_n;
  logic pclk_seen;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;

  anc_extract_fifo_and_parallel_out #(.HALF_DEPTH(DEPTH))
    i_anc_extract_fifo_and_parallel_out (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_link_clock(i_link_clock),
    .i_reset_n_pin(i_reset_n_pin),
    .i_buffer_enable_pin(i_buffer_enable_pin),
    .i_processing_enable_pin(i_processing_enable_pin),
    .i_video_format_pin(i_video_format_pin),
    .i_stream_format_pin(i_stream_format_pin),
    .i_mode_write(i_mode_write), .i_mode_wdata(i_mode_wdata),
    .i_anc_capture_enable(i_anc_capture_enable),
    .i_anc_bank_swap(i_anc_bank_swap), .i_frame_start(i_frame_start),
    .i_anc_valid(i_anc_valid), .i_anc_word(i_anc_word),
    .i_video_word(i_video_word), .i_stream_byte(i_stream_byte),
    .i_code_error_flag(i_code_error_flag),
    .i_stuffing_flag(i_stuffing_flag), .i_auto_mode(i_auto_mode),
    .i_trs_found(i_trs_found), .i_sync_found(i_sync_found),
    .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr), .o_mode(o_mode),
    .o_bypass(o_bypass), .o_anc_buffer_ready(o_anc_buffer_ready),
    .o_anc_present_flag(o_anc_present_flag), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .o_dout(o_dout), .o_dout_oe_n(o_dout_oe_n),
    .o_pclk(o_pclk), .o_pclk_oe_n(o_pclk_oe_n));
  anc_source i_anc_source (.i_clock(i_clock), .o_link_clock(i_link_clock),
    .o_anc_valid(i_anc_valid), .o_anc_word(i_anc_word));

  always #5 i_clock = ~i_clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [9:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      n_mismatch++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic tend(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr_mode(input logic [1:0] m);
    i_mode_write = 1'b1;
    i_mode_wdata = m;
    cyc(1);
    i_mode_write = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [10:0] a, input logic [7:0] exp);
    i_rd_en   = 1'b1;
    i_rd_addr = a;
    cyc(1);
    i_rd_en = 1'b0;
    chk("rd_valid", 10'(o_rd_valid), 10'h1);
    chk("rd_data", 10'(o_rd_data), 10'(exp));
    cyc(1);
  endtask

  // Swaps only while no packet is arriving, then keeps the minimum gap.
  task automatic swap;
    i_anc_bank_swap = ~i_anc_bank_swap;
    cyc(1100);
  endtask

  task automatic wait_ready;
    int k;
    k = 0;
    while (o_anc_buffer_ready !== 1'b1 && k < 2400)
    begin
      cyc(1);
      k++;
    end
    chk("ready_delay", 10'(k > 2150 && k < 2230), 10'h1);
  endtask

  function automatic logic [7:0] pk(logic [7:0] b, int n, int i);
    return (i == 3) ? 8'(n - 5) : b + 8'(i);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      test_done;
    end
  end

  initial
  begin
    {i_clock, i_buffer_enable_pin, i_processing_enable_pin} = 3'h0;
    {i_video_format_pin, i_stream_format_pin, i_mode_write} = 3'h0;
    {i_anc_capture_enable, i_anc_bank_swap, i_frame_start} = 3'h0;
    {i_auto_mode, i_trs_found, i_sync_found, i_rd_en} = 4'h0;
    {i_mode_wdata, i_rd_addr, i_stream_byte} = 21'h0;
    {i_code_error_flag, i_stuffing_flag, i_video_word} = 12'h0;
    i_sys_rst = 1'b1;
    i_reset_n_pin = 1'b1;
    cyc(16);
    i_sys_rst = 1'b0;
    cyc(4);
    chk("mode", 10'(o_mode), 10'h3);
    chk("bypass", 10'(o_bypass), 10'h1);
    tend("reset");
    {i_buffer_enable_pin, i_processing_enable_pin} = 2'h3;
    {i_video_format_pin, i_auto_mode} = 2'h3;
    {i_video_word, i_stream_byte, i_code_error_flag} = 19'h54B87;
    wr_mode(2'h0);
    chk("mode", 10'(o_mode), 10'h0);
    cyc(40);
    chk("bypass", 10'(o_bypass), 10'h0);
    chk("dout", o_dout, 10'h2A5);
    {i_video_format_pin, i_stream_format_pin} = 2'h1;
    i_stuffing_flag = 1'b1;
    cyc(40);
    chk("dout", o_dout, 10'h3C3);
    i_stream_format_pin = 1'b0;
    cyc(40);
    chk("dout", o_dout, 10'h000);
    chk("mode", 10'(o_mode), 10'h3);
    chk("bypass", 10'(o_bypass), 10'h1);
    i_trs_found = 1'b1;
    cyc(40);
    chk("dout", o_dout, 10'h2A5);
    i_reset_n_pin = 1'b0;
    cyc(5);
    chk("dout_oe_n", 10'(o_dout_oe_n), 10'h1);
    chk("pclk_oe_n", 10'(o_pclk_oe_n), 10'h1);
    i_reset_n_pin = 1'b1;
    cyc(5);
    chk("dout_oe_n", 10'(o_dout_oe_n), 10'h0);
    chk("pclk_oe_n", 10'(o_pclk_oe_n), 10'h0);
    pclk_seen = o_pclk;
    cyc(8);
    chk("pclk", 10'(o_pclk), 10'(pclk_seen == 1'b0));
    tend("output");
    i_video_format_pin = 1'b1;
    wr_mode(2'h2);
    chk("mode", 10'(o_mode), 10'h2);
    chk("ready", 10'(o_anc_buffer_ready), 10'h0);
    wait_ready;
    i_anc_capture_enable = 1'b1;
    i_anc_source.send(8'h10, 6);
    cyc(2);
    rd(11'h02C, 8'h00);
    i_frame_start = 1'b1;
    cyc(1);
    i_frame_start = 1'b0;
    fork
      i_anc_source.send(8'h20, 8);
      begin
        cyc(4);
        chk("present", 10'(o_anc_present_flag), 10'h1);
      end
    join
    cyc(2);
    chk("present", 10'(o_anc_present_flag), 10'h0);
    i_anc_capture_enable = 1'b0;
    i_anc_source.send(8'h40, 12);
    cyc(2);
    rd(11'h02F, 8'h03);
    for (int i = 0; i < DEPTH; i++)
      rd(11'h02C + 11'(i),
         i < 8 ? pk(8'h20, 8, i) : pk(8'h40, 12, i - 8));
    rd(11'h02C + 11'(DEPTH), 8'h00);
    rd(11'h02B, 8'h00);
    tend("capture");
    swap;
    rd(11'h02C, pk(8'h20, 8, 0));
    i_anc_source.send(8'h60, 6);
    swap;
    rd(11'h02C, pk(8'h60, 6, 0));
    rd(11'h032, 8'h00);
    swap;
    rd(11'h02D, pk(8'h60, 6, 1));
    i_anc_source.send(8'h80, 5);
    swap;
    rd(11'h02C, pk(8'h80, 5, 0));
    rd(11'h031, 8'h00);
    tend("swap");
    wr_mode(2'h3);
    chk("bypass", 10'(o_bypass), 10'h1);
    wr_mode(2'h2);
    i_anc_capture_enable = 1'b1;
    wait_ready;
    i_anc_source.send(8'hB0, 4);
    cyc(2);
    rd(11'h02C, pk(8'hB0, 4, 0));
    i_buffer_enable_pin = 1'b0;
    cyc(4);
    i_buffer_enable_pin = 1'b1;
    wait_ready;
    rd(11'h02C, 8'h00);
    i_anc_source.send(8'hC0, 3);
    cyc(2);
    rd(11'h02E, pk(8'hC0, 3, 2));
    repeat (4) swap;
    rd(11'h02C, 8'h00);
    i_processing_enable_pin = 1'b0;
    cyc(4);
    chk("bypass", 10'(o_bypass), 10'h1);
    tend("reentry");
    test_done;
  end
endmodule
